// [rtl/rms_and_active_power_dsp.sv]
// Purpose: Current/voltage rms and gain-trimmed active power datapath
// Assumes: Samples and zero-cross pulse synchronous to core_clk_in
// Notes:   One rate tick every RATE_DIV clocks drives both filters
`include "rms_power_defines.svh"
`default_nettype none

// Behaviour
// - Rms is the square root of the low-pass averaged squared samples.
// - Rms averaging filter corner near 2 Hz at the nominal clock rate.
// - Current and voltage rms computed together, each in a 24-bit register.
// - Current rms LSB equals one current sample LSB.
// - Rms results refresh once every five clocks by default.
// - Zero-cross update bit set: rms results load only on voltage zero crossings.
// - Current rms delivered through the waveform register when selected and enabled.
// - Waveform copy of current rms keeps its low 21 bits, shifted up 3; high bits dropped.
// - Full-scale current rms near 0x172BA3 or 0x1CF68C by gain stage.
// - Current rms is sqrt of mean square plus trim times 32768.
// - Voltage rms gets 64 times its signed trim added linearly.
// - Full-scale voltage swings 0x28F5 to 0xD70B; rms near 0x1CF68C.
// - Power is current times voltage, averaged by a separate low-pass filter.
// - Twice line frequency ripple may remain on active power.
// - Active power scaled by one plus signed 12-bit gain trim over 4096.
module rms_and_active_power_dsp #(
   parameter int unsigned RMS_LPF_SHIFT = `RMS_LPF_SHIFT,
   parameter int unsigned PWR_LPF_SHIFT = `PWR_LPF_SHIFT
) (
   input  wire logic                     core_clk_in,
   input  wire logic                     nrst_in,
   input  wire rms_power_pkg::reg_req_t  reg_req_in,
   input  wire rms_power_pkg::sample_t   smp_in,
   output logic [23:0]                   reg_rdata_out,
   output logic                          irq_out
);
   import rms_power_pkg::*;

   localparam int unsigned PW = 40 + PWR_LPF_SHIFT;

   // ------------------------------------------------------------
   // Registers and rate tick
   // ------------------------------------------------------------
   logic [2:0]         div_q;
   logic [7:0]         mode_q, wsrc_q, irqen_q, wcnt_q;
   logic [11:0]        itrim_q, vtrim_q, active_power_gain_trim_q;
   logic [2:0]         stat_q, stat_d;
   logic [23:0]        irms_q, voltage_rms_result_q, pwr_q, wave_q, rdata_q, rdata_d;
   logic               irq_q;
   logic [63:0]        ms_acc_q [2];
   logic [47:0]        sq_w [2];
   logic [47:0]        rad_w [2];
   logic [47:0]        rad_q [2][25];
   logic [23:0]        root_q [2][25];
   logic signed [PW-1:0] pacc_q;

   wire tick = (div_q == 3'h0);

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         div_q <= 3'h0;
      end else begin
         div_q <= (div_q == 3'(`RATE_DIV - 1)) ? 3'h0 : div_q + 3'h1;
      end
   end

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   wire       wr       = reg_req_in.wr;
   wire [7:0] ad       = reg_req_in.addr;
   wire       wr_mode  = wr && (ad == `OFS_MODE_CFG);
   wire       wr_wsrc  = wr && (ad == `OFS_WAVE_SRC);
   wire       wr_irqen = wr && (ad == `OFS_IRQ_EN_UP);
   wire       wr_itrim = wr && (ad == `OFS_IRMS_TRIM);
   wire       wr_vtrim = wr && (ad == `OFS_VOLTAGE_RMS_RESULT_TRIM);
   wire       wr_gain  = wr && (ad == `OFS_PWR_GAIN);
   wire       wr_stat  = wr && (ad == `OFS_IRQ_STAT);
   wire       zx_mode  = mode_q[`RMS_ZX_UPD_BIT];
   wire       waveform_sample_irq_enable     = irqen_q[`IRQ_WAVE_BIT];
   wire       src_irms = (wsrc_q[`WAVE_SEL_LSB +: 2] == WSRC_IRMS);
   wire [1:0] wrate    = wsrc_q[`WAVE_RATE_LSB +: 2];

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         mode_q  <= `CFG8_RST;
         wsrc_q  <= `CFG8_RST;
         irqen_q <= `CFG8_RST;
         itrim_q <= `TRIM_RST;
         vtrim_q <= `TRIM_RST;
         active_power_gain_trim_q <= `TRIM_RST;
      end else begin
         if (wr_mode)  mode_q  <= reg_req_in.wdata[7:0];
         if (wr_wsrc)  wsrc_q  <= reg_req_in.wdata[7:0];
         if (wr_irqen) irqen_q <= reg_req_in.wdata[7:0];
         if (wr_itrim) itrim_q <= reg_req_in.wdata[11:0];
         if (wr_vtrim) vtrim_q <= reg_req_in.wdata[11:0];
         if (wr_gain)  active_power_gain_trim_q <= reg_req_in.wdata[11:0];
      end
   end

   // ------------------------------------------------------------
   // Rms: square, average, root
   // ------------------------------------------------------------
   // Voltage samples are aligned up so both channels share one root width
   wire signed [23:0] v_al = {smp_in.volt, 8'h00};
   wire signed [47:0] isq_s = smp_in.cur * smp_in.cur;
   wire signed [47:0] vsq_s = v_al * v_al;
   assign sq_w[0] = isq_s;
   assign sq_w[1] = vsq_s;

   // Current trim acts on the square, so it is added ahead of the root
   wire signed [49:0] itrim_x = {{38{itrim_q[11]}}, itrim_q} <<< `IRMS_TRIM_SH;
   wire signed [49:0] irad_s  = $signed({2'b00, ms_acc_q[0][RMS_LPF_SHIFT +: 48]}) + itrim_x;
   assign rad_w[0] = irad_s[49] ? 48'h0 : irad_s[47:0];
   assign rad_w[1] = ms_acc_q[1][RMS_LPF_SHIFT +: 48];

   for (genvar c = 0; c < 2; c++) begin : g_ch
      // One-pole averager; shift 16 at the divided rate puts the corner near 2 Hz
      always_ff @(posedge core_clk_in) begin
         if (!nrst_in) begin
            ms_acc_q[c] <= 64'h0;
         end else if (tick) begin
            ms_acc_q[c] <= ms_acc_q[c] + {16'h0, sq_w[c]} - (ms_acc_q[c] >> RMS_LPF_SHIFT);
         end
      end
      always_ff @(posedge core_clk_in) begin
         if (!nrst_in) begin
            rad_q[c][0]  <= 48'h0;
            root_q[c][0] <= 24'h0;
         end else begin
            rad_q[c][0]  <= rad_w[c];
            root_q[c][0] <= 24'h0;
         end
      end
      // Pipelined root, one bit per stage: full rate, latency 25 clocks
      for (genvar s = 0; s < 24; s++) begin : g_stage
         localparam logic [23:0] BITV = 24'h1 << (23 - s);
         wire [23:0] trial = root_q[c][s] | BITV;
         wire [47:0] tsq   = 48'(trial) * 48'(trial);
         always_ff @(posedge core_clk_in) begin
            if (!nrst_in) begin
               rad_q[c][s+1]  <= 48'h0;
               root_q[c][s+1] <= 24'h0;
            end else begin
               rad_q[c][s+1]  <= rad_q[c][s];
               root_q[c][s+1] <= (tsq <= rad_q[c][s]) ? trial : root_q[c][s];
            end
         end
      end
   end

   // Full-scale codes follow from the upstream gain stage, not from this root
   wire [23:0] iroot = root_q[0][24];
   wire [23:0] vroot = root_q[1][24];
   // Voltage trim is linear after the root; result clamped to the 24-bit range
   wire signed [25:0] vtrim_x = {{14{vtrim_q[11]}}, vtrim_q} <<< `VOLTAGE_RMS_RESULT_TRIM_SH;
   wire signed [25:0] vsum    = $signed({2'b00, vroot}) + vtrim_x;
   wire [23:0] vsat = vsum[25] ? 24'h0 : (vsum[24] ? 24'hFFFFFF : vsum[23:0]);
   wire        upd  = zx_mode ? smp_in.zx : tick;

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         irms_q <= 24'h0;
         voltage_rms_result_q <= 24'h0;
      end else if (upd) begin
         irms_q <= iroot;
         voltage_rms_result_q <= vsat;
      end
   end

   // ------------------------------------------------------------
   // Active power
   // ------------------------------------------------------------
   wire signed [39:0]   prod   = smp_in.cur * smp_in.volt;
   wire signed [39:0]   pavg   = 40'(pacc_q >>> PWR_LPF_SHIFT);
   wire signed [25:0]   pw26   = 26'(pavg >>> `PWR_OUT_SHIFT);
   wire signed [37:0]   pprod  = pw26 * $signed(active_power_gain_trim_q);
   wire signed [26:0]   pg     = 27'(pw26) + 27'(pprod >>> `GAIN_SH);
   wire                 p_hi   = (pg > 27'sh07FFFFF);
   wire                 p_lo   = (pg < -27'sh0800000);
   wire [23:0] psat = p_hi ? 24'h7FFFFF : (p_lo ? 24'h800000 : pg[23:0]);

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         pacc_q <= '0;
         pwr_q  <= 24'h0;
      end else if (tick) begin
         // Short averager: double line frequency ripple is left for the energy stage
         pacc_q <= pacc_q + PW'(prod) - (pacc_q >>> PWR_LPF_SHIFT);
         pwr_q  <= psat;
      end
   end

   // ------------------------------------------------------------
   // Waveform path
   // ------------------------------------------------------------
   wire [7:0] wlast   = 8'((9'(`WAVE_BASE_TICK) << wrate) - 9'h1);
   wire       wave_ev = tick && (wcnt_q == wlast);
   wire       wave_ld = wave_ev && src_irms && waveform_sample_irq_enable;

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         wcnt_q <= 8'h00;
         wave_q <= 24'h0;
      end else begin
         if (tick) wcnt_q <= (wcnt_q >= wlast) ? 8'h00 : wcnt_q + 8'h01;
         // From 0x200000 upward, one eighth of the 24-bit range, the top bits fall off by design
         if (wave_ld) wave_q <= {irms_q[23-`WAVE_IRMS_SH:0], `WAVE_IRMS_SH'(0)};
      end
   end

   // ------------------------------------------------------------
   // Status, interrupt and read port
   // ------------------------------------------------------------
   wire [2:0] ev  = {tick, upd, wave_ld};
   wire [2:0] clr = wr_stat ? reg_req_in.wdata[2:0] : 3'h0;
   // Set beats clear so an event in the clearing cycle survives
   assign stat_d = (stat_q & ~clr) | ev;

   always_comb begin
      rdata_d = 24'h0;
      if (reg_req_in.rd) begin
         case (ad)
            `OFS_MODE_CFG:  rdata_d = {16'h0, mode_q};
            `OFS_WAVE_SRC:  rdata_d = {16'h0, wsrc_q};
            `OFS_IRQ_EN_UP: rdata_d = {16'h0, irqen_q};
            `OFS_IRMS:      rdata_d = irms_q;
            `OFS_VOLTAGE_RMS_RESULT:      rdata_d = voltage_rms_result_q;
            `OFS_IRMS_TRIM: rdata_d = {12'h0, itrim_q};
            `OFS_VOLTAGE_RMS_RESULT_TRIM: rdata_d = {12'h0, vtrim_q};
            `OFS_PWR_GAIN:  rdata_d = {12'h0, active_power_gain_trim_q};
            `OFS_POWER:     rdata_d = pwr_q;
            `OFS_WAVEFORM:  rdata_d = wave_q;
            `OFS_IRQ_STAT:  rdata_d = {21'h0, stat_q};
            default:        rdata_d = 24'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         stat_q  <= 3'h0;
         irq_q   <= 1'b0;
         rdata_q <= 24'h0;
      end else begin
         stat_q  <= stat_d;
         irq_q   <= |(stat_d & irqen_q[2:0]);
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign irq_out       = irq_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   wire [24:0] r1   = {1'b0, iroot} + 25'h1;
   wire [49:0] r1sq = r1 * r1;

   a_tick_period: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      tick |=> !tick [*4] ##1 tick) else $error("rate tick not every five clocks");

   a_root_exact: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      (48'(iroot) * 48'(iroot) <= rad_q[0][24]) && (r1sq > {2'b00, rad_q[0][24]}))
      else $error("current root not exact");

   a_rms_rate: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      (!zx_mode && tick) |=> (irms_q == $past(iroot)) && (voltage_rms_result_q == $past(vsat)))
      else $error("rms results not loaded on tick");

   a_zx_hold: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      (zx_mode && !smp_in.zx) |=> $stable(irms_q) && $stable(voltage_rms_result_q))
      else $error("rms changed without zero crossing");

   a_vtrim_add: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      (upd && !vtrim_q[11] && vroot < 24'h100000)
      |=> voltage_rms_result_q == $past(vroot) + {$past(vtrim_q), 6'h00})
      else $error("voltage trim not 64 per step");

   a_clamp_zero: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      irad_s[49] |-> ##25 (iroot == 24'h0)) else $error("negative radicand not clamped");

   a_gain_unity: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      (tick && active_power_gain_trim_q == 12'h000 && !p_hi && !p_lo) |=> pwr_q == $past(pw26[23:0]))
      else $error("zero gain trim altered power");

   a_filter_hold: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      !tick |=> $stable(pacc_q) && $stable(ms_acc_q[0]) && $stable(ms_acc_q[1]))
      else $error("filters moved off tick");

   a_wave_trunc: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      wave_ld |=> wave_q == {$past(irms_q[20:0]), 3'h0})
      else $error("waveform copy of rms wrong");

   a_wave_gate: assert property (
      @(posedge core_clk_in) disable iff (!nrst_in)
      (!src_irms || !waveform_sample_irq_enable) |=> $stable(wave_q)) else $error("waveform loaded while off");

endmodule : rms_and_active_power_dsp
`default_nettype wire

// [shared/rms_power_defines.svh]
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: 8-bit register addresses, 24-bit register data
// Notes:   Offsets of trims, results and status sit in otherwise free space
`ifndef RMS_POWER_DEFINES_SVH
`define RMS_POWER_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_MODE_CFG   8'h0C
`define OFS_WAVE_SRC   8'h0D
`define OFS_IRQ_EN_UP  8'hDB
`define OFS_IRMS       8'h20
`define OFS_VOLTAGE_RMS_RESULT       8'h21
`define OFS_IRMS_TRIM  8'h22
`define OFS_VOLTAGE_RMS_RESULT_TRIM  8'h23
`define OFS_PWR_GAIN   8'h24
`define OFS_POWER      8'h25
`define OFS_WAVEFORM   8'h26
`define OFS_IRQ_STAT   8'h27

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define RMS_ZX_UPD_BIT 0
`define WAVE_SEL_LSB   0
`define WAVE_RATE_LSB  3
`define IRQ_WAVE_BIT   0
`define IRQ_RMS_BIT    1
`define IRQ_PWR_BIT    2
`define CFG8_RST       8'h00
`define TRIM_RST       12'h000

// ------------------------------------------------------------
// Timing and scaling
// ------------------------------------------------------------
`define RATE_DIV       5
`define WAVE_BASE_TICK 32
`define RMS_LPF_SHIFT  16
`define PWR_LPF_SHIFT  10
`define PWR_OUT_SHIFT  14
`define IRMS_TRIM_SH   15
`define VOLTAGE_RMS_RESULT_TRIM_SH   6
`define GAIN_SH        12
`define VOLT_ALIGN_SH  8
`define WAVE_IRMS_SH   3

`endif

// [shared/rms_power_pkg.sv]
// Purpose: Types shared by the rms and active power datapath
// Assumes: Nothing beyond the defines header
// Notes:   Carriers are packed structs
`default_nettype none
package rms_power_pkg;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [23:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic signed [23:0] cur;
      logic signed [15:0] volt;
      logic               zx;
   } sample_t;

   typedef enum logic [1:0] {
      WSRC_CUR   = 2'h0,
      WSRC_VOLT  = 2'h1,
      WSRC_POWER = 2'h2,
      WSRC_IRMS  = 2'h3
   } wave_src_t;
endpackage : rms_power_pkg
`default_nettype wire

// [tb/sample_source.sv]
// Purpose: Far-side model of the digitised current and voltage sample paths
// Assumes: Bench sets the levels and the zero-cross request at clock edges
// Notes:   Samples are registered once, as a real filter output would be
`default_nettype none
module sample_source (
   input  wire logic                    clk_in,
   input  wire logic                    nrst_in,
   input  wire logic signed [23:0]      cur_in,
   input  wire logic signed [15:0]      volt_in,
   input  wire logic                    zx_in,
   output var  rms_power_pkg::sample_t  smp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import rms_power_pkg::*;
   // -----------------------------------------------------------
   // Stream
   // -----------------------------------------------------------
   // Zero-cross is registered as given, so a level held on zx_in stays a level on smp_out.zx, not one pulse
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         smp_out <= '0;
      end else begin
         smp_out <= '{cur: cur_in, volt: volt_in, zx: zx_in};
      end
   end
endmodule : sample_source
`default_nettype wire

// [tb/rms_and_active_power_dsp_test.sv]
// Purpose: Self-checking bench for the rms and active power datapath
// Assumes: Short filter shifts so dc inputs settle in a few thousand clocks
// Notes:   Dc inputs make current rms equal the level, voltage rms 256 times it; a tolerance covers filter rounding
`include "rms_power_defines.svh"
`default_nettype none
module rms_and_active_power_dsp_test;
   timeunit 1ns;
   timeprecision 1ps;
   import rms_power_pkg::*;
   // -----------------------------------------------------------
   // Signals
   // -----------------------------------------------------------
   logic                core_clk = 1'b0;
   logic                nrst     = 1'b0;
   reg_req_t            req      = '0;
   logic signed [23:0]  cur      = 24'h000000;
   logic signed [15:0]  volt     = 16'h0000;
   logic                zx       = 1'b0;
   sample_t             smp;
   logic [23:0]         rdata;
   logic                irq;
   int                  n_mismatch = 0;
   int                  n_checks   = 0;
   logic [7:0]          ra[10] = '{8'h0C, 8'h0D, 8'hDB, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24,
                                   8'h25, 8'h26};
   logic [11:0]         gv[3]  = '{12'h7FF, 12'h800, 12'h000};

   always #2 core_clk = ~core_clk;

   sample_source src (.clk_in(core_clk), .nrst_in(nrst), .cur_in(cur), .volt_in(volt),
                      .zx_in(zx), .smp_out(smp));

   rms_and_active_power_dsp #(.RMS_LPF_SHIFT(4), .PWR_LPF_SHIFT(2)) uut (
      .core_clk_in(core_clk), .nrst_in(nrst), .reg_req_in(req), .smp_in(smp),
      .reg_rdata_out(rdata), .irq_out(irq));
   // -----------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   task chk(input string nm, input logic [23:0] e, input logic [23:0] g, input int tol);
      int d;
      d = int'(g) - int'(e);
      n_checks++;
      if ($isunknown(g) || d > tol || d < -tol) begin
         n_mismatch++;
         $display("BAD %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge core_clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk) req <= '0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are taken there
   task rchk(input logic [7:0] a, input logic [23:0] e, input int tol, input string nm);
      @(posedge core_clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h000000};
      @(posedge core_clk) req <= '0;
      #1;
      chk(nm, e, rdata, tol);
   endtask : rchk

   task wait_irq(input int lim);
      int i;
      for (i = 0; i < lim && irq !== 1'b1; i++) @(posedge core_clk);
      if (i == lim) begin
         n_mismatch++;
         $display("BAD irq_wait exp 1 got %b", irq);
         test_done();
      end
   endtask : wait_irq
   // -----------------------------------------------------------
   // Sequence
   // -----------------------------------------------------------
   initial begin
      cyc(8);
      nrst <= 1'b1;
      cyc(2);
      foreach (ra[i]) rchk(ra[i], 24'h000000, 0, "reset_value");
      chk("irq_reset", 24'h000000, {23'h0, irq}, 0);
      wr(8'h22, 24'hFFFFFF);
      rchk(8'h22, 24'h000FFF, 0, "trim_width");
      wr(8'h21, 24'h000123);
      rchk(8'h21, 24'h000000, 0, "ro_write");
      wr(8'h30, 24'h0000AA);
      rchk(8'h30, 24'h000000, 0, "unmapped");
      wr(8'h22, 24'h000000);
      cur <= 24'h004000;
      volt <= 16'h0100;
      cyc(4000);
      // Bench plays the processor: it compares raw codes, unit scaling is its own job
      rchk(8'h20, 24'h004000, 2, "irms_dc");
      rchk(8'h21, 24'h010000, 2, "voltage_rms_result_dc");
      rchk(8'h25, 24'h000100, 2, "power_dc");
      for (int i = 0; i < 3; i++) begin
         wr(8'h24, {12'h000, gv[i]});
         cyc(20);
         rchk(8'h25, 24'((256 * (4096 + int'($signed(gv[i])))) / 4096), 2, "gain");
      end
      wr(8'h23, 24'h000002);
      cyc(100);
      rchk(8'h21, 24'h010080, 2, "voltage_rms_result_trim_pos");
      wr(8'h23, 24'h000FFF);
      cyc(100);
      rchk(8'h21, 24'h00FFC0, 2, "voltage_rms_result_trim_neg");
      wr(8'h22, 24'h000001);
      cyc(100);
      rchk(8'h20, 24'h004000, 2, "irms_trim");
      // A small level with the most negative trim drives the radicand below zero
      wr(8'h22, 24'h000800);
      cur <= 24'h000064;
      cyc(4000);
      rchk(8'h20, 24'h000000, 0, "irms_clamp");
      wr(8'h22, 24'h000000);
      cur <= 24'h004000;
      cyc(4000);
      wr(8'h0C, 24'h000001);
      wr(8'hDB, 24'h000002);
      wr(8'h27, 24'h000007);
      cyc(3);
      chk("irq_no_zx", 24'h000000, {23'h0, irq}, 0);
      cur <= 24'h002000;
      cyc(4000);
      rchk(8'h20, 24'h004000, 2, "irms_hold");
      @(posedge core_clk) zx <= 1'b1;
      @(posedge core_clk) zx <= 1'b0;
      cyc(40);
      rchk(8'h20, 24'h002000, 2, "irms_zx");
      chk("irq_rms", 24'h000001, {23'h0, irq}, 0);
      wr(8'h27, 24'h000002);
      cyc(3);
      chk("irq_clear", 24'h000000, {23'h0, irq}, 0);
      zx <= 1'b1;
      @(posedge core_clk) zx <= 1'b0;
      cyc(3);
      rchk(8'h27, 24'h000006, 0, "status");
      wr(8'hDB, 24'h000000);
      cyc(3);
      chk("irq_masked", 24'h000000, {23'h0, irq}, 0);
      // Back to tick updates with a level whose scaled copy overflows 24 bits
      wr(8'h0C, 24'h000000);
      cur <= 24'h300000;
      cyc(5000);
      rchk(8'h20, 24'h300000, 2, "irms_tick");
      wr(8'hDB, 24'h000001);
      for (int r = 0; r < 4; r++) begin
         wr(8'h0D, 24'(r * 8 + 3));
         wr(8'h27, 24'h000001);
         cyc(3);
         wait_irq((32 << r) * 5 + 20);
         rchk(8'h26, 24'h800000, 16, "wave_irms");
      end
      test_done();
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      n_mismatch++;
      $display("BAD watchdog exp done got running");
      test_done();
   end
endmodule : rms_and_active_power_dsp_test
`default_nettype wire
